//--- src/tsr_pkg.sv
// Package: constants and types of the temperature readout target
// ****************************************************************
// Operation
// - Answer only fixed address 0101111
// - Support write, read, send, receive byte
// - Receive byte returns last commanded register
// - Channel temperatures at offsets 00h, 01h
// - Unsigned byte, one degree per step
// - Temperature bytes leave most significant first
// - Three fraction bits at 05h, 06h
// - Negative temperatures read as zero
// - Extended read freezes integer update 0.25s
// - Integer read ends the freeze early
// - Convert from reset onward at 4Hz
// ****************************************************************
package tsr_pkg;

    // ************************************************************
    // Bus addressing and register map
    // ************************************************************
    localparam logic [6:0] TSR_DEV_ADDR  = 7'h2f;
    localparam logic [7:0] TSR_OFF_T1    = 8'h00;
    localparam logic [7:0] TSR_OFF_T2    = 8'h01;
    localparam logic [7:0] TSR_OFF_X1    = 8'h05;
    localparam logic [7:0] TSR_OFF_X2    = 8'h06;
    localparam logic [7:0] TSR_UNMAPPED  = 8'h00;
    localparam logic [3:0] TSR_BITS_BYTE = 4'h8;

    // ************************************************************
    // Result layout: signed eighths of a degree
    // ************************************************************
    localparam int TSR_RAW_W    = 12;
    localparam int TSR_SIGN_POS = 11;
    localparam int TSR_INT_LSB  = 3;
    localparam int TSR_FRAC_LSB = 5;
    localparam logic [7:0] TSR_TEMP_RST = 8'h00;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int TSR_CLK_HZ      = 20_000_000;
    localparam int TSR_CONV_MS     = 250;
    localparam int TSR_LOCK_MS     = 250;
    localparam int TSR_CONV_CYC    = TSR_CONV_MS * (TSR_CLK_HZ / 1000);
    localparam int TSR_LOCK_CYC    = TSR_LOCK_MS * (TSR_CLK_HZ / 1000);
    localparam int TSR_TMR_W       = 23;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ADDR = 4'h1,
        ST_AACK = 4'h3,
        ST_CMD  = 4'h2,
        ST_CACK = 4'h6,
        ST_DATA = 4'h7,
        ST_DACK = 4'h5,
        ST_TX   = 4'h4,
        ST_TACK = 4'hc,
        ST_WAIT = 4'hd
    } tsr_st_e;

    typedef struct packed {
        logic                             done;
        logic [1:0][TSR_RAW_W-1:0]        raw;
    } tsr_conv_s;

    typedef struct packed {
        tsr_st_e                          st;
        logic                             scl_m;
        logic                             scl_s;
        logic                             scl_p;
        logic                             sda_m;
        logic                             sda_s;
        logic                             sda_p;
        logic [7:0]                       sh;
        logic [3:0]                       cnt;
        logic                             rw;
        logic [7:0]                       cmd;
        logic                             oe;
        logic                             sdo;
        logic [TSR_TMR_W-1:0]             tmr;
        logic                             start;
        logic [1:0][7:0]                  t;
        logic [1:0][7:0]                  x;
        logic [1:0]                       lk;
        logic [1:0][TSR_TMR_W-1:0]        lc;
    } tsr_state_s;

    localparam tsr_state_s TSR_STATE_RST = '0;

endpackage

//--- src/tsr_smbus_target.sv
// Module: serial target with temperature result registers and lock
`timescale 1ns/10ps
module tsr_smbus_target
    import tsr_pkg::*;
#(
    parameter int unsigned CONV_CYC = TSR_CONV_CYC,
    parameter int unsigned LOCK_CYC = TSR_LOCK_CYC
) (
    // Clock and reset
    input  wire logic      clk_i,
    input  wire logic      reset_i,
    // Serial pins
    input  wire logic      scl_i,
    input  wire logic      sda_i,
    output logic           sda_o,
    output logic           sda_oe_o,
    // Converter
    input  wire tsr_conv_s conv_i,
    output logic           conv_start_o
);

    localparam logic [TSR_TMR_W-1:0] CONV_LAST = TSR_TMR_W'(CONV_CYC - 1);
    localparam logic [TSR_TMR_W-1:0] LOCK_LOAD = TSR_TMR_W'(LOCK_CYC - 1);

    tsr_state_s q;
    tsr_state_s d;

    logic rise;
    logic fall;
    logic start_c;
    logic stop_c;

    assign rise    = q.scl_s & ~q.scl_p;
    assign fall    = ~q.scl_s & q.scl_p;
    assign start_c = q.scl_s & q.scl_p & q.sda_p & ~q.sda_s;
    assign stop_c  = q.scl_s & q.scl_p & ~q.sda_p & q.sda_s;

    function automatic logic [7:0] rd_byte(input logic [7:0] c, input tsr_state_s s);
        unique case (c)
            TSR_OFF_T1: rd_byte = s.t[0];
            TSR_OFF_T2: rd_byte = s.t[1];
            TSR_OFF_X1: rd_byte = s.x[0];
            TSR_OFF_X2: rd_byte = s.x[1];
            default:    rd_byte = TSR_UNMAPPED;
        endcase
    endfunction

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        logic       ld;
        logic [7:0] sel;
        logic [TSR_RAW_W-1:0] r;
        ld  = 1'b0;
        sel = 8'h00;
        r   = '0;
        d   = q;
        // Pins pass two flops before any edge logic
        d.scl_m = scl_i;
        d.scl_s = q.scl_m;
        d.scl_p = q.scl_s;
        d.sda_m = sda_i;
        d.sda_s = q.sda_m;
        d.sda_p = q.sda_s;

        // Free running conversion tick, first one right after reset
        d.start = (q.tmr == '0);
        d.tmr   = (q.tmr == CONV_LAST) ? '0 : q.tmr + 1'b1;

        for (int i = 0; i < 2; i++) begin
            r = conv_i.raw[i];
            if (q.lk[i]) begin
                if (q.lc[i] == '0) begin
                    d.lk[i] = 1'b0;
                end else begin
                    d.lc[i] = q.lc[i] - 1'b1;
                end
            end
            // Locked pair keeps both bytes from one conversion
            if (conv_i.done && !q.lk[i]) begin
                if (r[TSR_SIGN_POS]) begin
                    d.t[i] = TSR_TEMP_RST;
                    d.x[i] = TSR_TEMP_RST;
                end else begin
                    d.t[i] = r[TSR_INT_LSB +: 8];
                    d.x[i] = {r[TSR_INT_LSB-1:0], 5'h00};
                end
            end
        end

        if (q.st == ST_ADDR || q.st == ST_CMD || q.st == ST_DATA) begin
            if (rise) begin
                d.sh  = {q.sh[6:0], q.sda_s};
                d.cnt = q.cnt + 4'h1;
            end
        end

        unique case (q.st)
            ST_IDLE: begin
            end
            ST_ADDR: begin
                if (fall && q.cnt == TSR_BITS_BYTE) begin
                    d.cnt = 4'h0;
                    if (q.sh[7:1] == TSR_DEV_ADDR) begin
                        d.st = ST_AACK;
                        d.oe = 1'b1;
                        d.rw = q.sh[0];
                    end else begin
                        d.st = ST_WAIT;
                    end
                end
            end
            ST_AACK: begin
                if (fall) begin
                    d.oe = 1'b0;
                    if (q.rw) begin
                        ld   = 1'b1;
                        d.st = ST_TX;
                    end else begin
                        d.st = ST_CMD;
                    end
                end
            end
            ST_CMD: begin
                if (fall && q.cnt == TSR_BITS_BYTE) begin
                    d.cmd = q.sh;
                    d.cnt = 4'h0;
                    d.oe  = 1'b1;
                    d.st  = ST_CACK;
                end
            end
            ST_CACK: begin
                if (fall) begin
                    d.oe = 1'b0;
                    d.st = ST_DATA;
                end
            end
            ST_DATA: begin
                // All registers here are read only, data is acked and dropped
                if (fall && q.cnt == TSR_BITS_BYTE) begin
                    d.cnt = 4'h0;
                    d.oe  = 1'b1;
                    d.st  = ST_DACK;
                end
            end
            ST_DACK: begin
                if (fall) begin
                    d.oe = 1'b0;
                    d.st = ST_WAIT;
                end
            end
            ST_TX: begin
                if (rise) begin
                    d.cnt = q.cnt + 4'h1;
                end
                if (fall) begin
                    if (q.cnt == TSR_BITS_BYTE) begin
                        d.oe  = 1'b0;
                        d.cnt = 4'h0;
                        d.st  = ST_TACK;
                    end else begin
                        d.oe = ~q.sh[7];
                        d.sh = {q.sh[6:0], 1'b0};
                    end
                end
            end
            ST_TACK: begin
                if (rise && q.sda_s) begin
                    d.st = ST_WAIT;
                end
                if (fall) begin
                    ld   = 1'b1;
                    d.st = ST_TX;
                end
            end
            ST_WAIT: begin
            end
            default: begin
                d.st = ST_IDLE;
            end
        endcase

        // Byte load for the host; reads have side effects on the lock
        if (ld) begin
            sel   = rd_byte(q.cmd, q);
            d.sh  = {sel[6:0], 1'b0};
            d.oe  = ~sel[7];
            d.cnt = 4'h0;
            for (int i = 0; i < 2; i++) begin
                if (q.cmd == (i == 0 ? TSR_OFF_X1 : TSR_OFF_X2)) begin
                    d.lk[i] = 1'b1;
                    d.lc[i] = LOCK_LOAD;
                end
                if (q.cmd == (i == 0 ? TSR_OFF_T1 : TSR_OFF_T2)) begin
                    d.lk[i] = 1'b0;
                end
            end
        end

        // Start and stop win over any phase
        if (start_c) begin
            d.st  = ST_ADDR;
            d.cnt = 4'h0;
            d.oe  = 1'b0;
        end
        if (stop_c) begin
            d.st = ST_IDLE;
            d.oe = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            q <= TSR_STATE_RST;
        end else begin
            q <= d;
        end
    end

    assign sda_o        = q.sdo;
    assign sda_oe_o     = q.oe;
    assign conv_start_o = q.start;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    // Byte a read would load now, kept as a net so checks can look back at it
    logic [7:0] tx_pick;
    assign tx_pick = rd_byte(q.cmd, q);

    chk_addr_nack: assert property (
        (q.st == ST_ADDR && fall && q.cnt == 4'h8 && q.sh[7:1] != TSR_DEV_ADDR)
        |=> (q.st == ST_WAIT && !q.oe))
        else $error("foreign address acknowledged");

    chk_ack_drive: assert property (
        (q.st == ST_CMD && fall && q.cnt == 4'h8 && !start_c && !stop_c)
        |=> (q.oe && q.cmd == $past(q.sh)))
        else $error("command byte not acked");

    chk_msb_first: assert property (
        (q.st == ST_TX && fall && q.cnt != 4'h8 && !stop_c)
        |=> (q.oe == !$past(q.sh[7])))
        else $error("tx bit order wrong");

    chk_rx_select: assert property (
        (q.st == ST_AACK && fall && q.rw && !stop_c)
        |=> (q.oe == !$past(tx_pick[7])))
        else $error("first bit not from selected register");

    chk_host_nack: assert property (
        (q.st == ST_TX && fall && q.cnt == 4'h8) |=> !q.oe ##0 q.st != ST_TX)
        else $error("data line not released for host ack");

    chk_neg_clip: assert property (
        (conv_i.done && conv_i.raw[0][TSR_SIGN_POS] && !q.lk[0])
        |=> (q.t[0] == 8'h00 && q.x[0] == 8'h00))
        else $error("negative not clipped");

    chk_int_value: assert property (
        (conv_i.done && !conv_i.raw[1][TSR_SIGN_POS] && !q.lk[1])
        |=> (q.t[1] == $past(conv_i.raw[1][10:3])
             && q.x[1][7:5] == $past(conv_i.raw[1][2:0])))
        else $error("result byte mismatch");

    chk_lock_hold: assert property (
        q.lk[0] |=> ($stable(q.t[0]) && $stable(q.x[0])))
        else $error("locked result updated");

    chk_lock_end: assert property (
        (((q.st == ST_AACK && q.rw) || q.st == ST_TACK) && fall && q.cmd == TSR_OFF_T1)
        |=> !q.lk[0])
        else $error("integer read kept lock");

    chk_lock_arm: assert property (
        (q.st == ST_AACK && fall && q.rw && q.cmd == TSR_OFF_X2)
        |=> (q.lk[1] && q.lc[1] == LOCK_LOAD))
        else $error("extended read did not arm lock");

    chk_data_ack: assert property (
        (q.st == ST_DATA && fall && q.cnt == 4'h8)
        |=> (q.oe && q.st == ST_DACK))
        else $error("data byte not acked");

    chk_stop_idle: assert property (
        stop_c |=> (q.st == ST_IDLE && !q.oe))
        else $error("stop did not release the bus");

    chk_idle_quiet: assert property (
        (q.st == ST_IDLE || q.st == ST_WAIT) |-> !q.oe)
        else $error("data line driven while idle");

    chk_conv_tick: assert property (
        conv_start_o |=> (!conv_start_o && q.tmr == TSR_TMR_W'(2)))
        else $error("conversion tick malformed");

    cov_read_byte:  cover property (q.st == ST_TACK && rise && q.sda_s);
    cov_write_byte: cover property (q.st == ST_DACK && fall);
    cov_lock_set:   cover property ($rose(q.lk[1]));
    cov_send_byte:  cover property (q.st == ST_DATA && stop_c);
    cov_lock_out:   cover property ($fell(q.lk[1]) && q.lc[1] == '0);

endmodule // tsr_smbus_target

//--- sim/tsr_host_model.sv
// Bus host model driving the serial pins of the temperature target
`timescale 1ns/10ps
module tsr_host_model #(
    parameter int HALF = 4
) (
    // Clock
    input  wire logic clk_i,
    // Serial pins
    input  wire logic dev_oe_i,
    output logic      scl_o,
    output logic      sda_o
);
    logic pull_q;

    // Open drain with pull-up, released line reads high
    assign sda_o = ~(pull_q | dev_oe_i);

    initial begin
        scl_o  = 1'b1;
        pull_q = 1'b0;
    end

    task automatic wt();
        repeat (HALF) @(negedge clk_i);
    endtask

    // Also the repeated start, entered with clock low
    task automatic start();
        pull_q = 1'b0;
        wt();
        scl_o = 1'b1;
        wt();
        pull_q = 1'b1;
        wt();
        scl_o = 1'b0;
        wt();
    endtask

    task automatic stop();
        pull_q = 1'b1;
        wt();
        scl_o = 1'b1;
        wt();
        pull_q = 1'b0;
        wt();
    endtask

    // Data moves mid low phase only, never next to a clock edge
    task automatic bit_io(input logic b, output logic r);
        pull_q = ~b;
        wt();
        scl_o = 1'b1;
        wt();
        r     = sda_o;
        scl_o = 1'b0;
        wt();
    endtask

    // Single master here, so the short forms are safe
    task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx, output logic ack_n);
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
        bit_io(1'b1, ack_n);
    endtask
endmodule // tsr_host_model

//--- sim/testbench.sv
// Self-checking bench of the temperature readout serial target
`timescale 1ns/10ps
module testbench
    import tsr_pkg::*;
;
    localparam int CONV = 200;
    localparam int LOCK = 3000;
    logic       clk_i      = 1'b0;
    logic       reset_i    = 1'b1;
    logic       scl, sda, sda_o, sda_oe, conv_start;
    logic [7:0] junk;
    tsr_conv_s  conv       = '0;
    int         mismatches = 0;
    int         tests_run  = 0;

    always #25 clk_i = ~clk_i;

    tsr_host_model #(.HALF(4)) host (.clk_i(clk_i), .dev_oe_i(sda_oe), .scl_o(scl),
        .sda_o(sda));
    tsr_smbus_target #(.CONV_CYC(CONV), .LOCK_CYC(LOCK)) DUT (.clk_i(clk_i),
        .reset_i(reset_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe),
        .conv_i(conv), .conv_start_o(conv_start));

    // ****************************************************
    // Helpers
    // ****************************************************
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic addr(input logic [6:0] a7, input logic rw, input logic exp_n);
        logic a;
        host.start();
        host.byte_io({a7, rw}, junk, a);
        check("address ack", {7'h0, a}, {7'h0, exp_n});
    endtask

    task automatic put(input logic [7:0] b);
        logic a;
        host.byte_io(b, junk, a);
        check("byte ack", {7'h0, a}, 8'h00);
    endtask

    task automatic get(input logic [7:0] exp);
        logic [7:0] d;
        logic       n;
        host.byte_io(8'hff, d, n);
        host.stop();
        check("data byte", d, exp);
    endtask

    task automatic rd(input logic [7:0] c, input logic [7:0] exp);
        addr(TSR_DEV_ADDR, 1'b0, 1'b0);
        put(c);
        addr(TSR_DEV_ADDR, 1'b1, 1'b0);
        get(exp);
    endtask

    task automatic cvt(input logic [11:0] r1, input logic [11:0] r2);
        @(negedge clk_i);
        conv.raw[0] = r1;
        conv.raw[1] = r2;
        conv.done   = 1'b1;
        @(negedge clk_i);
        conv.done = 1'b0;
    endtask

    // ****************************************************
    // Scenarios
    // ****************************************************
    task automatic s_rate();
        int n;
        n = 0;
        while (conv_start !== 1'b1 && n < 2 * CONV) begin
            @(negedge clk_i);
            n++;
        end
        check("first start", (n <= 3) ? 8'h01 : 8'h00, 8'h01);
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
        end while (conv_start !== 1'b1 && n < 2 * CONV);
        check("start period", n[7:0], 8'(CONV));
    endtask

    // Extended first so the integer reads drop the locks again
    task automatic s_reset_vals();
        rd(TSR_OFF_X1, 8'h00);
        rd(TSR_OFF_X2, 8'h00);
        rd(TSR_OFF_T1, 8'h00);
        rd(TSR_OFF_T2, 8'h00);
    endtask

    task automatic s_decode();
        cvt(12'h0cc, 12'h78f);
        rd(TSR_OFF_T1, 8'h19);
        rd(TSR_OFF_T2, 8'hf1);
        rd(TSR_OFF_X2, 8'he0);
        rd(TSR_OFF_X1, 8'h80);
    endtask

    task automatic s_lock();
        cvt(12'hff8, 12'h800);
        rd(TSR_OFF_T2, 8'hf1);
        rd(TSR_OFF_X1, 8'h80);
        rd(TSR_OFF_T1, 8'h19);
        cvt(12'hff8, 12'h800);
        rd(TSR_OFF_X2, 8'h00);
        rd(TSR_OFF_T1, 8'h00);
        repeat (LOCK) @(negedge clk_i);
        cvt(12'h0cc, 12'h78f);
        rd(TSR_OFF_X2, 8'he0);
    endtask

    // Write data is dropped, every register is read only
    task automatic s_short_forms();
        addr(TSR_DEV_ADDR, 1'b0, 1'b0);
        put(TSR_OFF_T2);
        put(8'h55);
        host.stop();
        addr(TSR_DEV_ADDR, 1'b1, 1'b0);
        get(8'hf1);
        addr(TSR_DEV_ADDR, 1'b0, 1'b0);
        put(TSR_OFF_T1);
        host.stop();
        addr(TSR_DEV_ADDR, 1'b1, 1'b0);
        get(8'h19);
        addr(7'h2e, 1'b0, 1'b1);
        host.stop();
        rd(8'h02, 8'h00);
    endtask

    // Host acks the first byte, so the same register comes again
    task automatic s_repeat();
        logic [7:0] d;
        logic       n;
        addr(TSR_DEV_ADDR, 1'b0, 1'b0);
        put(TSR_OFF_T1);
        host.stop();
        addr(TSR_DEV_ADDR, 1'b1, 1'b0);
        for (int i = 7; i >= 0; i--) begin
            host.bit_io(1'b1, d[i]);
        end
        host.bit_io(1'b0, n);
        check("first of two", d, 8'h19);
        get(8'h19);
    endtask

    initial begin
        repeat (6) @(negedge clk_i);
        reset_i = 1'b0;
        s_rate();
        s_reset_vals();
        s_decode();
        s_lock();
        s_short_forms();
        s_repeat();
        check("data out", {7'h0, sda_o}, 8'h00);
        give_verdict();
    end
endmodule // testbench
